// ### core/dpf_pin_assign.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpf_regs.svh"
module dpf_pin_assign
  import dpf_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // APB register port
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  // Host bus pins
  input  wire logic         busStyle,
  input  wire logic         chipEnable_n,
  input  wire logic         readWriteLine,
  input  wire logic [3:0]   registerSelect,
  input  wire logic [7:0]   hostDataIn,
  output logic [7:0]        hostDataOut,
  output logic              hostDataOe_n,
  output logic              transferAck_n,
  output logic              transferAckOe_n,
  // Multipurpose pins
  input  wire logic [6:0]   multiIn,
  output logic [7:2]        multiOutVal,
  output logic [7:2]        multiOutOe_n,
  // Device core side
  input  wire dpf_devSig_t  devSig,
  input  wire logic [7:0]   hostRdata,
  output dpf_chanCtl_t      chanCtl,
  output dpf_hostReq_t      hostReq
);

  dpf_state_t st_ff;
  dpf_state_t nxt_st;
  dpf_pinIn_t pinNow;
  logic       apbSetup;
  logic       apbAccess;
  logic       apbHit;
  logic [31:0] rdMux;
  logic [2:0] evtSet;
  logic [2:0] evtClr;
  logic [3:0] irqEn;
  logic [3:0] irqBit;
  logic       fallTxA;
  logic       fallTxB;
  logic       riseRxA;
  logic       riseRxB;
  logic       riseCt;

  // Every pin input enters through the two-stage synchroniser
  assign pinNow = '{style: busStyle, chip_enable_n: chipEnable_n,
                    rw: readWriteLine, addr: registerSelect,
                    data: hostDataIn, mIn: multiIn};

  // APB decode; access completes in one cycle
  assign apbSetup  = psel & ~penable;
  assign apbAccess = psel & penable;
  assign pready    = 1'b1;
  always_comb begin
    apbHit = 1'b1;
    rdMux  = 32'h0000_0000;
    unique case (paddr)
      `DPF_OFS_OUT_CFG:  rdMux[7:0] = st_ff.ocfg;
      `DPF_OFS_GP_OUT:   rdMux[7:0] = st_ff.gp;
      `DPF_OFS_IN_CFG:   rdMux[6:0] = st_ff.icfg;
      `DPF_OFS_IN_STATE: begin
        rdMux[6:0] = st_ff.s2.mIn;
        rdMux[`DPF_IN_STYLE_BIT] = st_ff.s2.style;
      end
      `DPF_OFS_EVT_STAT: rdMux[2:0] = st_ff.evt;
      `DPF_OFS_EVT_MASK: rdMux[2:0] = st_ff.mask;
      default:           apbHit = 1'b0;
    endcase
  end
  assign pslverr = apbAccess & ~apbHit;

  // Edge detection uses only the second stage and its delayed copy
  assign fallTxA = st_ff.prevIn[3] & ~st_ff.s2.mIn[3];
  assign riseRxA = ~st_ff.prevIn[4] & st_ff.s2.mIn[4];
  assign fallTxB = st_ff.prevIn[5] & ~st_ff.s2.mIn[5];
  assign riseRxB = ~st_ff.prevIn[6] & st_ff.s2.mIn[6];
  assign riseCt  = ~st_ff.prevIn[2] & st_ff.s2.mIn[2];

  // Events; a CTS change only counts while the input serves as CTS
  always_comb begin
    evtSet = 3'h0;
    evtSet[`DPF_EVT_CTS_A] = st_ff.icfg.ctsA &
                             (st_ff.prevIn[0] ^ st_ff.s2.mIn[0]);
    evtSet[`DPF_EVT_CTS_B] = st_ff.icfg.ctsB &
                             (st_ff.prevIn[1] ^ st_ff.s2.mIn[1]);
    evtSet[`DPF_EVT_HOST]  = (st_ff.hs == HS_XFER);
    evtClr = 3'h0;
    if (apbAccess && pwrite && paddr == `DPF_OFS_EVT_STAT) begin
      evtClr = pwdata[2:0];
    end
  end

  // Interrupt pin sources for outputs four to seven
  assign irqEn  = {st_ff.ocfg.op7Irq, st_ff.ocfg.op6Irq,
                   st_ff.ocfg.op5Irq, st_ff.ocfg.op4Irq};
  assign irqBit = {devSig.interrupt_status_bits[4], devSig.interrupt_status_bits[0],
                   devSig.interrupt_status_bits[5], devSig.interrupt_status_bits[1]};

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1     = pinNow;
    nxt_st.s2     = st_ff.s1;
    nxt_st.prevIn = st_ff.s2.mIn;
    // Set beats a clear arriving in the same cycle
    nxt_st.evt = (st_ff.evt & ~evtClr) | evtSet;

    // Register writes and read data capture
    if (apbSetup) begin
      nxt_st.prdata = rdMux;
    end
    if (apbAccess && pwrite) begin
      unique case (paddr)
        `DPF_OFS_OUT_CFG:  nxt_st.ocfg = dpf_outCfg_t'(pwdata[7:0]);
        `DPF_OFS_GP_OUT:   nxt_st.gp = pwdata[7:0];
        `DPF_OFS_IN_CFG:   nxt_st.icfg = dpf_inCfg_t'(pwdata[6:0]);
        `DPF_OFS_EVT_MASK: nxt_st.mask = pwdata[2:0];
        default: ;
      endcase
    end

    // Second output is always push-pull
    nxt_st.mOe_n[2] = 1'b0;
    unique case (st_ff.ocfg.op2)
      OP2_GP:    nxt_st.mOut[2] = st_ff.gp[2];
      OP2_TXA16: nxt_st.mOut[2] = devSig.txClkA16;
      OP2_TXA1:  nxt_st.mOut[2] = devSig.txClkA1;
      OP2_RXA1:  nxt_st.mOut[2] = devSig.rxClkA1;
    endcase

    // Timer function pulls low only; the pin floats otherwise
    nxt_st.mOe_n[3] = 1'b0;
    unique case (st_ff.ocfg.op3)
      OP3_GP:   nxt_st.mOut[3] = st_ff.gp[3];
      OP3_CT: begin
        nxt_st.mOut[3]  = 1'b0;
        nxt_st.mOe_n[3] = ~devSig.ctOut;
      end
      OP3_TXB1: nxt_st.mOut[3] = devSig.txClkB1;
      OP3_RXB1: nxt_st.mOut[3] = devSig.rxClkB1;
    endcase

    // Interrupt pins: open-drain low while the status bit is set
    for (int i = 0; i < 4; i++) begin
      if (irqEn[i]) begin
        nxt_st.mOut[i+4]  = 1'b0;
        nxt_st.mOe_n[i+4] = ~irqBit[i];
      end else begin
        nxt_st.mOut[i+4]  = st_ff.gp[i+4];
        nxt_st.mOe_n[i+4] = 1'b0;
      end
    end

    // Input functions; unused CTS reads as asserted
    nxt_st.chan.gpIn     = st_ff.s2.mIn;
    nxt_st.chan.ctsA_n   = st_ff.icfg.ctsA ? st_ff.s2.mIn[0] : 1'b0;
    nxt_st.chan.ctsB_n   = st_ff.icfg.ctsB ? st_ff.s2.mIn[1] : 1'b0;
    nxt_st.chan.ctTick   = st_ff.icfg.ctExt & riseCt;
    nxt_st.chan.txShiftA = st_ff.icfg.txExtA & fallTxA;
    nxt_st.chan.txShiftB = st_ff.icfg.txExtB & fallTxB;
    nxt_st.chan.rxSampleA = st_ff.icfg.rxExtA & riseRxA;
    nxt_st.chan.rxSampleB = st_ff.icfg.rxExtB & riseRxB;

    // Host port; the request strobe lasts one cycle
    nxt_st.req.valid = 1'b0;
    unique case (st_ff.hs)
      HS_IDLE: begin
        nxt_st.dOe_n   = 1'b1;
        nxt_st.ackOe_n = 1'b1;
        nxt_st.ackOut  = 1'b1;
        // Only the read/write-line flavour is served here
        if (!st_ff.s2.chip_enable_n && !st_ff.s2.style) begin
          nxt_st.req.valid = 1'b1;
          nxt_st.req.write = ~st_ff.s2.rw;
          nxt_st.req.addr  = st_ff.s2.addr;
          nxt_st.req.wdata = st_ff.s2.data;
          nxt_st.hs = HS_XFER;
        end
      end
      HS_XFER: begin
        // Core answers a read in the same cycle as the strobe
        nxt_st.dOut    = hostRdata;
        nxt_st.dOe_n   = st_ff.req.write;
        nxt_st.ackOut  = 1'b0;
        nxt_st.ackOe_n = 1'b0;
        nxt_st.hs = HS_HOLD;
      end
      HS_HOLD: begin
        if (st_ff.s2.chip_enable_n) begin
          nxt_st.dOe_n   = 1'b1;
          nxt_st.ackOut  = 1'b1;
          nxt_st.ackOe_n = 1'b1;
          nxt_st.hs = HS_IDLE;
        end
      end
      default: nxt_st.hs = HS_IDLE;
    endcase
  end

  // Single state register; pins come up high and bus released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.s1.chip_enable_n   <= 1'b1;
      st_ff.s2.chip_enable_n   <= 1'b1;
      st_ff.ocfg     <= dpf_outCfg_t'(`DPF_RST_OUT_CFG);
      st_ff.gp       <= `DPF_RST_GP_OUT;
      st_ff.icfg     <= dpf_inCfg_t'(`DPF_RST_IN_CFG);
      st_ff.evt      <= `DPF_RST_EVT;
      st_ff.mask     <= `DPF_RST_EVT;
      st_ff.mOut     <= 6'h3f;
      st_ff.hs       <= HS_IDLE;
      st_ff.dOe_n    <= 1'b1;
      st_ff.ackOut   <= 1'b1;
      st_ff.ackOe_n  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from the state register; irq ORs the unmasked event bits
  assign prdata          = st_ff.prdata;
  assign irq             = |(st_ff.evt & st_ff.mask);
  assign hostDataOut     = st_ff.dOut;
  assign hostDataOe_n    = st_ff.dOe_n;
  assign transferAck_n   = st_ff.ackOut;
  assign transferAckOe_n = st_ff.ackOe_n;
  assign multiOutVal     = st_ff.mOut;
  assign multiOutOe_n    = st_ff.mOe_n;
  assign chanCtl         = st_ff.chan;
  assign hostReq         = st_ff.req;

  // Checks on the pin functions and host port
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_rx_irq_pin: assert property (
    (st_ff.ocfg.op4Irq && devSig.interrupt_status_bits[1])
      |=> (!multiOutOe_n[4] && !multiOutVal[4]))
    else $error("rx irq pin A not pulled low");
  a_tx_irq_pin: assert property (
    (st_ff.ocfg.op7Irq && !devSig.interrupt_status_bits[4]) |=> multiOutOe_n[7])
    else $error("tx irq pin B driven while idle");
  a_ct_pin: assert property (
    (st_ff.ocfg.op3 == OP3_CT) |=>
      (!multiOutVal[3] && multiOutOe_n[3] == !$past(devSig.ctOut)))
    else $error("timer pin not open-drain");
  a_op2_clk: assert property (
    (st_ff.ocfg.op2 == OP2_RXA1)
      |=> multiOutVal[2] == $past(devSig.rxClkA1))
    else $error("second output not carrying rx clock");
  a_op3_clk: assert property (
    (st_ff.ocfg.op3 == OP3_TXB1)
      |=> multiOutVal[3] == $past(devSig.txClkB1))
    else $error("third output not carrying tx clock");
  a_cts_pass: assert property (
    st_ff.icfg.ctsA |=> chanCtl.ctsA_n == $past(st_ff.s2.mIn[0]))
    else $error("clear-to-send A not passed");
  a_ct_tick: assert property (
    (st_ff.icfg.ctExt && riseCt) |=> chanCtl.ctTick)
    else $error("timer clock edge lost");
  a_tx_fall: assert property (
    chanCtl.txShiftA |-> $past(fallTxA && st_ff.icfg.txExtA))
    else $error("tx shift not on falling edge");
  a_rx_rise: assert property (
    (st_ff.icfg.rxExtA && riseRxA) |=> chanCtl.rxSampleA)
    else $error("rx sample not on rising edge");
  a_style_idle: assert property (
    (st_ff.hs == HS_IDLE && st_ff.s2.style) |=> st_ff.hs == HS_IDLE)
    else $error("transfer started in other bus flavour");
  a_bus_off: assert property (
    st_ff.s2.chip_enable_n [*2] |-> hostDataOe_n)
    else $error("data bus driven with chip enable high");
  a_ack_xfer: assert property (
    (st_ff.hs == HS_XFER) |=> (!transferAck_n && !transferAckOe_n))
    else $error("transfer not acknowledged");
  a_gp_out: assert property (
    !st_ff.ocfg.op5Irq |=>
      (multiOutVal[5] == $past(st_ff.gp[5]) && !multiOutOe_n[5]))
    else $error("general output not driven");

  // Remaining pins and host port details
  a_rx_irq_b: assert property (
    (st_ff.ocfg.op5Irq && devSig.interrupt_status_bits[5])
      |=> (!multiOutOe_n[5] && !multiOutVal[5]))
    else $error("rx irq pin B not pulled low");
  a_tx_irq_a: assert property (
    (st_ff.ocfg.op6Irq && devSig.interrupt_status_bits[0])
      |=> (!multiOutOe_n[6] && !multiOutVal[6]))
    else $error("tx irq pin A not pulled low");
  a_op2_fast: assert property (
    (st_ff.ocfg.op2 == OP2_TXA16)
      |=> multiOutVal[2] == $past(devSig.txClkA16))
    else $error("second output not carrying fast tx clock");
  a_op3_rx: assert property (
    (st_ff.ocfg.op3 == OP3_RXB1)
      |=> multiOutVal[3] == $past(devSig.rxClkB1))
    else $error("third output not carrying rx clock");
  a_cts_b: assert property (
    st_ff.icfg.ctsB |=> chanCtl.ctsB_n == $past(st_ff.s2.mIn[1]))
    else $error("clear-to-send B not passed");
  a_tx_fall_b: assert property (
    chanCtl.txShiftB |-> $past(fallTxB && st_ff.icfg.txExtB))
    else $error("tx B shift not on falling edge");
  a_rx_rise_b: assert property (
    (st_ff.icfg.rxExtB && riseRxB) |=> chanCtl.rxSampleB)
    else $error("rx B sample not on rising edge");
  a_read_data: assert property (
    (st_ff.hs == HS_XFER && !st_ff.req.write)
      |=> (hostDataOut == $past(hostRdata) && !hostDataOe_n))
    else $error("read byte not placed on data bus");
  a_req_pulse: assert property (
    hostReq.valid |=> !hostReq.valid)
    else $error("host request strobe longer than one cycle");
  a_ack_release: assert property (
    (st_ff.hs == HS_HOLD && st_ff.s2.chip_enable_n)
      |=> (transferAck_n && transferAckOe_n))
    else $error("acknowledge not released after transfer");

endmodule
`default_nettype wire

// ### core/dpf_pkg.sv
package dpf_pkg;
  typedef enum logic [1:0] {
    OP2_GP = 2'h0, OP2_TXA16 = 2'h1, OP2_TXA1 = 2'h2, OP2_RXA1 = 2'h3
  } dpf_op2Sel_t;
  typedef enum logic [1:0] {
    OP3_GP = 2'h0, OP3_CT = 2'h1, OP3_TXB1 = 2'h2, OP3_RXB1 = 2'h3
  } dpf_op3Sel_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h1, HS_XFER = 3'h2, HS_HOLD = 3'h4
  } dpf_hostSt_t;
  typedef struct packed {
    logic op7Irq; logic op6Irq; logic op5Irq; logic op4Irq;
    dpf_op3Sel_t op3; dpf_op2Sel_t op2;
  } dpf_outCfg_t;
  typedef struct packed {
    logic rxExtB; logic txExtB; logic rxExtA; logic txExtA;
    logic ctExt; logic ctsB; logic ctsA;
  } dpf_inCfg_t;
  typedef struct packed {
    logic style; logic chip_enable_n; logic rw; logic [3:0] addr;
    logic [7:0] data; logic [6:0] mIn;
  } dpf_pinIn_t;
  typedef struct packed {
    logic txClkA16; logic txClkA1; logic rxClkA1;
    logic txClkB1; logic rxClkB1; logic ctOut; logic [7:0] interrupt_status_bits;
  } dpf_devSig_t;
  typedef struct packed {
    logic ctsA_n; logic ctsB_n; logic ctTick;
    logic txShiftA; logic rxSampleA; logic txShiftB; logic rxSampleB;
    logic [6:0] gpIn;
  } dpf_chanCtl_t;
  typedef struct packed {
    logic valid; logic write; logic [3:0] addr; logic [7:0] wdata;
  } dpf_hostReq_t;
  typedef struct packed {
    dpf_pinIn_t s1; dpf_pinIn_t s2; logic [6:0] prevIn;
    dpf_outCfg_t ocfg; logic [7:0] gp; dpf_inCfg_t icfg;
    logic [2:0] evt; logic [2:0] mask; logic [31:0] prdata;
    logic [7:2] mOut; logic [7:2] mOe_n; dpf_chanCtl_t chan;
    dpf_hostReq_t req; dpf_hostSt_t hs;
    logic [7:0] dOut; logic dOe_n; logic ackOut; logic ackOe_n;
  } dpf_state_t;
endpackage

// ### core/dpf_regs.svh
`ifndef DPF_REGS_SVH
`define DPF_REGS_SVH
// APB byte offsets
`define DPF_OFS_OUT_CFG   8'h00
`define DPF_OFS_GP_OUT    8'h04
`define DPF_OFS_IN_CFG    8'h08
`define DPF_OFS_IN_STATE  8'h0c
`define DPF_OFS_EVT_STAT  8'h10
`define DPF_OFS_EVT_MASK  8'h14
// Reset values
`define DPF_RST_OUT_CFG   8'h00
`define DPF_RST_GP_OUT    8'hff
`define DPF_RST_IN_CFG    7'h00
`define DPF_RST_EVT       3'h0
// Field positions
`define DPF_EVT_CTS_A     0
`define DPF_EVT_CTS_B     1
`define DPF_EVT_HOST      2
`define DPF_IN_STYLE_BIT  7
`endif

// ### verif/dpf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dpf_host_model (
  // Clock
  input  wire logic       mclk,
  // Device side of the host pins
  input  wire logic [7:0] devData,
  input  wire logic       devDataOe_n,
  input  wire logic       ack_n,
  input  wire logic       ackOe_n,
  // Host pins
  output logic            chip_enable_n,
  output logic            rw,
  output logic [3:0]      addr,
  output logic [7:0]      bus
);
  logic [7:0] hostD = 8'h00;
  logic       hostDrv = 1'b0;
  logic [7:0] last = 8'h00;
  initial begin
    chip_enable_n = 1'b1;
    rw = 1'b1;
    addr = 4'h0;
  end
  // Undriven bus shows the inverse of its last value, never a held copy
  assign bus = !devDataOe_n ? devData : (hostDrv ? hostD : ~last);
  always @(posedge mclk) begin
    last <= bus;
  end
  // One cycle; pins hold until acknowledge, ok low unless acknowledged within 11 edges
  task automatic xfer(input logic wr, input logic [3:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    chip_enable_n <= 1'b0;
    rw <= ~wr;
    addr <= a;
    hostD <= d;
    hostDrv <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (!(ack_n === 1'b0 && ackOe_n === 1'b0) && n < 12);
    q = bus;
    ok = (n < 12);
    chip_enable_n <= 1'b1;
    hostDrv <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### verif/dpf_pin_assign_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "dpf_regs.svh"
module dpf_pin_assign_tb;
  import dpf_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, busStyle = 1'b0, pready, pslverr, irq;
  logic [7:0] paddr = 8'h00, hostRdata = 8'h00, hostDataOut, bus;
  logic [31:0] pwdata = 32'h0, prdata;
  logic hostDataOe_n, transferAck_n, transferAckOe_n, chip_enable_n, rw;
  logic [3:0] addr;
  logic [6:0] multiIn = 7'h00;
  logic [7:2] multiOutVal, multiOutOe_n;
  dpf_devSig_t devSig = '0;
  dpf_chanCtl_t chanCtl;
  dpf_hostReq_t hostReq;
  logic [7:0] nValid = 8'h00;
  int numErrors = 0;
  int checked = 0;
  int seed = 32'h809a_de1f;
  localparam int irqBit[4] = '{1, 5, 0, 4};
  always #12.5 mclk = ~mclk;
  dpf_pin_assign i_dpf_pin_assign (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .busStyle(busStyle), .chipEnable_n(chip_enable_n), .readWriteLine(rw),
    .registerSelect(addr), .hostDataIn(bus), .hostDataOut(hostDataOut),
    .hostDataOe_n(hostDataOe_n), .transferAck_n(transferAck_n),
    .transferAckOe_n(transferAckOe_n), .multiIn(multiIn),
    .multiOutVal(multiOutVal), .multiOutOe_n(multiOutOe_n),
    .devSig(devSig), .hostRdata(hostRdata), .chanCtl(chanCtl),
    .hostReq(hostReq));
  dpf_host_model i_host (.mclk(mclk), .devData(hostDataOut),
    .devDataOe_n(hostDataOe_n), .ack_n(transferAck_n),
    .ackOe_n(transferAckOe_n), .chip_enable_n(chip_enable_n), .rw(rw), .addr(addr),
    .bus(bus));
  // Count request pulses handed to the core
  always @(posedge mclk) begin
    if (hostReq.valid === 1'b1) nValid <= nValid + 8'h01;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic closeOut;
    $display("checked %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // APB master; one idle edge first so no signal is set twice at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts one chanCtl pulse kind over six edges
  task automatic pulses(input int b, output logic [3:0] n);
    logic [4:0] p;
    n = 4'h0;
    repeat (6) begin
      @(posedge mclk);
      p = {chanCtl.rxSampleB, chanCtl.txShiftB, chanCtl.rxSampleA,
           chanCtl.txShiftA, chanCtl.ctTick};
      n = n + {3'h0, p[b-2]};
    end
  endtask
  // Reference pin model: {Oe_n[7:2], Val[7:2]}; open-drain asserted = low
  function automatic logic [11:0] expPins(input logic [7:0] oc,
    input logic [7:0] gp, input dpf_devSig_t s);
    logic [5:0] v;
    logic [5:0] e;
    v = gp[7:2];
    e = 6'h00;
    case (oc[1:0])
      2'h1: v[0] = s.txClkA16;
      2'h2: v[0] = s.txClkA1;
      2'h3: v[0] = s.rxClkA1;
      default: ;
    endcase
    case (oc[3:2])
      2'h1: begin
        v[1] = 1'b0;
        e[1] = ~s.ctOut;
      end
      2'h2: v[1] = s.txClkB1;
      2'h3: v[1] = s.rxClkB1;
      default: ;
    endcase
    for (int k = 0; k < 4; k++) begin
      if (oc[4+k]) begin
        v[2+k] = 1'b0;
        e[2+k] = ~s.interrupt_status_bits[irqBit[k]];
      end
    end
    return {e, v};
  endfunction
  initial begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    closeOut();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] oc, gp, hd, hq;
    logic [3:0] a, c0, c1;
    logic w, ok;
    logic [31:0] x;
    logic [6:0] pm;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({17'h0, multiOutOe_n, multiOutVal, irq, hostDataOe_n,
         transferAckOe_n}, 32'h0000_01fb);
    // Every output selection pair, random sources
    for (int i = 0; i < 16; i++) begin
      oc = {4'($random(seed)), i[3:0]};
      gp = 8'($random(seed));
      devSig <= dpf_devSig_t'(14'($random(seed)));
      apb(1'b1, `DPF_OFS_GP_OUT, {24'h0, gp}, q, w);
      apb(1'b1, `DPF_OFS_OUT_CFG, {24'h0, oc}, q, w);
      apb(1'b0, `DPF_OFS_OUT_CFG, 32'h0, q, w);
      chk(q, {24'h0, oc});
      x = {20'h0, expPins(oc, gp, devSig)};
      chk({26'h0, multiOutVal}, {26'h0, x[5:0]});
      chk({26'h0, multiOutOe_n}, {26'h0, x[11:6]});
    end
    // Unmapped offset reads zero and answers with an error
    apb(1'b0, 8'h40, 32'h0, q, w);
    chk(q, 32'h0000_0000);
    chk({31'h0, w}, 32'h0000_0001);
    apb(1'b1, `DPF_OFS_EVT_STAT, 32'h0000_0007, q, w);
    apb(1'b1, `DPF_OFS_EVT_MASK, 32'h0000_0004, q, w);
    // Host cycles alternate read and write
    for (int i = 0; i < 8; i++) begin
      hd = 8'($random(seed));
      a = 4'($random(seed));
      hostRdata <= 8'($random(seed));
      i_host.xfer(i[0], a, hd, hq, ok);
      x = {27'h0, i[0], a};
      chk({27'h0, hostReq.write, hostReq.addr}, x);
      chk({31'h0, ok}, 32'h0000_0001);
      x = {24'h0, i[0] ? hd : hostRdata};
      chk({24'h0, i[0] ? hostReq.wdata : hq}, x);
      x = {21'h0, 3'b111, 8'(i + 1)};
      chk({21'h0, hostDataOe_n, transferAckOe_n, irq, nValid}, x);
    end
    apb(1'b0, `DPF_OFS_EVT_STAT, 32'h0, q, w);
    chk(q, 32'h0000_0004);
    apb(1'b1, `DPF_OFS_EVT_STAT, 32'h0000_0004, q, w);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    busStyle <= 1'b1;
    repeat (3) @(posedge mclk);
    i_host.xfer(1'b1, 4'h3, 8'h5a, hq, ok);
    x = {21'h0, 1'b0, 8'h08, 2'b11};
    chk({21'h0, ok, nValid, hostDataOe_n, transferAckOe_n}, x);
    // Clear-to-send routing, unused reads asserted
    pm = 7'h00;
    for (int i = 0; i < 4; i++) begin
      oc = 8'($random(seed));
      apb(1'b1, `DPF_OFS_IN_CFG, {30'h0, i[1:0]}, q, w);
      multiIn <= oc[6:0];
      repeat (4) @(posedge mclk);
      x = {30'h0, oc[0] & i[0], oc[1] & i[1]};
      chk({30'h0, chanCtl.ctsA_n, chanCtl.ctsB_n}, x);
      chk({25'h0, chanCtl.gpIn}, {25'h0, oc[6:0]});
      apb(1'b0, `DPF_OFS_IN_STATE, 32'h0, q, w);
      chk(q, {24'h0, 1'b1, oc[6:0]});
      // A clear-to-send change is an event only while routed
      apb(1'b0, `DPF_OFS_EVT_STAT, 32'h0, q, w);
      x = {30'h0, i[1] & (oc[1] ^ pm[1]), i[0] & (oc[0] ^ pm[0])};
      chk(q, x);
      apb(1'b1, `DPF_OFS_EVT_STAT, 32'h0000_0003, q, w);
      pm = oc[6:0];
    end
    multiIn <= 7'h00;
    apb(1'b1, `DPF_OFS_IN_CFG, 32'h0000_007c, q, w);
    // Rising then falling edge on each external clock input
    for (int b = 2; b < 7; b++) begin
      multiIn[b] <= 1'b1;
      pulses(b, c0);
      multiIn[b] <= 1'b0;
      pulses(b, c1);
      if (b == 2) chk({28'h0, c0 + c1}, 32'h1);
      else chk({24'h0, c0, c1}, b[0] ? 32'h01 : 32'h10);
    end
    closeOut();
  end
endmodule
`default_nettype wire
